/* rtl/serial_rx_map.svh */
`ifndef SERIAL_RX_MAP_SVH
`define SERIAL_RX_MAP_SVH

// register offsets (byte index on the 3-bit port)
`define OFS_CTRL_ONE 3'h0
`define OFS_CTRL_TWO 3'h1
`define OFS_CTRL_THREE 3'h2
`define OFS_STATUS_ONE 3'h3
`define OFS_DATA_BUF 3'h4
`define OFS_BREAK_CTRL 3'h5

// ctrl_reg_one fields
`define B_LOOPBACK 7
`define B_MOD_EN 6
`define B_TX_INV 5
`define B_CHAR_LEN 4
`define B_WAKE_SEL 3
`define B_IDLE_START 2
`define B_PAR_EN 1
`define B_PAR_ODD 0

// ctrl_reg_two fields
`define B_RX_FULL_IE 5
`define B_IDLE_IE 4
`define B_TX_EN 3
`define B_RX_EN 2
`define B_STANDBY 1

// ctrl_reg_three fields
`define B_RX_BIT8 7
`define B_OVR_IE 3
`define B_NOISE_IE 2
`define B_FRAME_IE 1
`define B_PAR_IE 0

// status_reg_one fields
`define B_TX_EMPTY 7
`define B_TX_DONE 6
`define B_RX_FULL 5
`define B_IDLE 4
`define B_OVR 3
`define B_NOISE 2
`define B_FRAME 1
`define B_PAR 0

// break_flag_ctrl_reg field
`define B_BRK_CLR 7

// reset values
`define RST_CTRL 8'h00
`define RST_STATUS 8'hC0

// idle character and data bit lengths in bit times (8-bit and 9-bit characters)
`define IDLE_BITS_SHORT 4'hA
`define IDLE_BITS_LONG 4'hB
`define DATA_BITS_SHORT 4'h8
`define DATA_BITS_LONG 4'h9

`endif

/* rtl/serial_rx_pkg.sv */
package serial_rx_pkg;

	// one-hot frame tracker states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_DATA = 3'h2,
		ST_STOP = 3'h4
	} rx_state_t;

endpackage : serial_rx_pkg

/* rtl/serial_rx_wakeup_ctrl.sv */
`timescale 1ns/1ps
`include "serial_rx_map.svh"

module serial_rx_wakeup_ctrl
	import serial_rx_pkg::*;
(
	input wire logic sys_clk, // 40 MHz module clock
	input wire logic resetn, // async reset, active low
	input wire logic [2:0] addr, // register index
	input wire logic [7:0] wdata, // write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	output logic [7:0] rdata, // read data, cycle after rd_stb
	input wire logic rx_pin_in, // receive pin level
	output logic rx_pin_out, // receive pin drive value
	output logic rx_pin_oe_n, // receive pin enable, low drives
	output logic tx_pin_out, // transmit pin drive value
	output logic tx_pin_oe_n, // transmit pin enable, low drives
	input wire logic [1:0] port_dout, // port data for the two pins
	input wire logic [1:0] port_dir, // port direction, 1 = output
	input wire logic tx_serial, // transmitter serial level
	output logic rx_line, // receiver input to bit sampler
	input wire logic bit_stb, // sampler: one bit decided
	input wire logic bit_val, // sampler: bit value
	input wire logic bit_noise, // sampler: bit was noisy
	input wire logic dbg_break, // debug break state
	input wire logic stop_mode, // processor stop mode
	output logic rx_irq, // receiver interrupt request
	output logic err_irq, // error interrupt request
	output logic tx_irq_allow, // transmitter interrupts permitted
	output logic baud_en, // baud generator enable
	output logic rx_enable, // receiver enabled
	output logic tx_enable, // transmitter enabled
	output logic wait_wake // ends processor wait state
);

	logic rst_q1_r, rst_n_r; // reset release synchroniser
	logic rxp_q1_r, rxp_q2_r; // receive pin synchroniser
	logic [7:0] ctrl1_r, ctrl2_r, ctrl3_r, bctl_r; // control registers
	logic tx_empty_r, tx_done_r, rx_full_r, idle_r; // status flags
	logic ovr_r, noise_r, frame_r, par_r; // error flags
	logic [7:0] buf_r; // received data buffer
	logic r8_r; // received ninth bit
	logic [5:0] arm_r; // first clear step seen per flag
	rx_state_t st_r, st_nxt; // frame tracker
	logic [3:0] cnt_r; // data bit index
	logic [8:0] sh_r; // receive shift register
	logic nacc_r; // noise seen in this character
	logic [3:0] ones_r, ones_nxt; // consecutive ones counter
	logic idle_arm_r; // one idle report per break in traffic

	// control fields
	wire loop_sel = ctrl1_r[`B_LOOPBACK];
	wire mod_en = ctrl1_r[`B_MOD_EN];
	wire tx_inv = ctrl1_r[`B_TX_INV];
	wire len9 = ctrl1_r[`B_CHAR_LEN];
	wire wake_adr = ctrl1_r[`B_WAKE_SEL];
	wire idle_count_start_sel = ctrl1_r[`B_IDLE_START];
	wire par_en = ctrl1_r[`B_PAR_EN];
	wire par_odd = ctrl1_r[`B_PAR_ODD];
	wire standby = ctrl2_r[`B_STANDBY];
	wire brk_clr = bctl_r[`B_BRK_CLR];

	wire run = ~stop_mode; // stop mode freezes the receiver, baud enable and status clears
	wire rx_on = run & mod_en & ctrl2_r[`B_RX_EN];
	wire stb = bit_stb & rx_on; // a bit the frame tracker may use
	// status may change by software only outside a protected break
	wire clr_ok = run & (~dbg_break | brk_clr);
	wire rd_stat = rd_stb & (addr == `OFS_STATUS_ONE) & clr_ok;
	wire rd_data = rd_stb & (addr == `OFS_DATA_BUF) & clr_ok;

	// threshold of ones for an idle character
	function automatic logic [3:0] idle_len(input logic l9);
		return l9 ? `IDLE_BITS_LONG : `IDLE_BITS_SHORT;
	endfunction : idle_len

	// character completion and its outcome
	wire done = stb & (st_r == ST_STOP);
	wire msb = len9 ? sh_r[8] : sh_r[7];
	wire par_bad = par_en & ((^(len9 ? sh_r : {1'b0, sh_r[7:0]})) != par_odd);
	wire adr_wake = done & standby & wake_adr & msb;
	wire take = done & (~standby | adr_wake) & ~rx_full_r;
	wire lost = done & ~standby & rx_full_r;
	wire idle_hit = stb & (ones_nxt == idle_len(len9)) & (ones_r != idle_len(len9));
	// in standby the count is not armed-gated, so a quiet line wakes at once
	wire idle_wake = stb & standby & ~wake_adr & (ones_nxt == idle_len(len9));
	wire idle_set = idle_hit & idle_arm_r & ~standby;

	// reset release: async assert, two-flop release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_n_r <= rst_q1_r;
		end
	end

	// receive pin crosses in from outside through two flops
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rxp_q1_r <= 1'b1;
			rxp_q2_r <= 1'b1;
		end else begin
			rxp_q1_r <= rx_pin_in;
			rxp_q2_r <= rxp_q1_r;
		end
	end

	// loopback needs both directions enabled to be meaningful
	always_comb begin
		if (loop_sel) begin
			rx_line = tx_inv ^ tx_serial;
		end else begin
			rx_line = rxp_q2_r;
		end
	end

	// pin ownership: the enabled module overrides port directions
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_pin_out <= 1'b1;
			tx_pin_oe_n <= 1'b1;
			rx_pin_out <= 1'b0;
			rx_pin_oe_n <= 1'b1;
		end else if (mod_en) begin
			tx_pin_out <= tx_inv ^ tx_serial;
			tx_pin_oe_n <= 1'b0;
			rx_pin_out <= 1'b0;
			rx_pin_oe_n <= 1'b1;
		end else begin
			tx_pin_out <= port_dout[0];
			tx_pin_oe_n <= ~port_dir[0];
			rx_pin_out <= port_dout[1];
			rx_pin_oe_n <= ~port_dir[1];
		end
	end

	// first control and break control registers; writes land even in stop mode (registers held)
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl1_r <= `RST_CTRL;
			bctl_r <= `RST_CTRL;
		end else if (wr_stb) begin
			if (addr == `OFS_CTRL_ONE) begin
				ctrl1_r <= wdata;
			end
			if (addr == `OFS_BREAK_CTRL) begin
				bctl_r <= wdata & 8'h80;
			end
		end
	end

	// second control register with hardware wakeup clear of standby
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl2_r <= `RST_CTRL;
		end else if (wr_stb && addr == `OFS_CTRL_TWO) begin
			// transmit and receive enables cannot change while the module is off
			ctrl2_r <= {2'b00, wdata[5:4],
				mod_en ? wdata[3:2] : ctrl2_r[3:2], wdata[1], 1'b0};
		end else if (adr_wake || idle_wake) begin
			ctrl2_r[`B_STANDBY] <= 1'b0;
		end
	end

	// third control register holds the error enables
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl3_r <= `RST_CTRL;
		end else if (wr_stb && addr == `OFS_CTRL_THREE) begin
			ctrl3_r <= {4'h0, wdata[3:0]};
		end
	end

	// frame tracker next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (!bit_val) begin
					st_nxt = ST_DATA; // start bit
				end
			end
			ST_DATA: begin
				if (cnt_r == (len9 ? `DATA_BITS_LONG : `DATA_BITS_SHORT) - 4'h1) begin
					st_nxt = ST_STOP;
				end
			end
			ST_STOP: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// frame tracker, shift register and noise accumulation
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 9'h000;
			nacc_r <= 1'b0;
		end else if (!rx_on) begin
			st_r <= ST_IDLE;
		end else if (stb) begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE) begin
				cnt_r <= 4'h0;
				nacc_r <= bit_noise;
			end else begin
				nacc_r <= nacc_r | bit_noise;
			end
			if (st_r == ST_DATA) begin
				sh_r[cnt_r] <= bit_val;
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end

	// consecutive ones count for idle detection
	always_comb begin
		if (!bit_val || (idle_count_start_sel && st_r != ST_IDLE)) begin
			ones_nxt = 4'h0;
		end else if (ones_r == idle_len(len9)) begin
			ones_nxt = ones_r; // saturate
		end else begin
			ones_nxt = ones_r + 4'h1;
		end
	end

	// ones counter and re-arm on each start bit
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ones_r <= 4'h0;
			idle_arm_r <= 1'b0;
		end else if (stb) begin
			ones_r <= ones_nxt;
			if (st_r == ST_IDLE && !bit_val) begin
				idle_arm_r <= 1'b1;
			end else if (idle_hit) begin
				idle_arm_r <= 1'b0;
			end
		end
	end

	// data buffer: loaded only when the character is accepted
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			buf_r <= 8'h00;
			r8_r <= 1'b0;
		end else if (take) begin
			buf_r <= sh_r[7:0];
			r8_r <= msb;
		end
	end

	// first clear step: status read arms the flags then seen set
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			arm_r <= 6'h00;
		end else if (rd_stat) begin
			arm_r <= {rx_full_r, idle_r, ovr_r, noise_r, frame_r, par_r};
		end else if (rd_data) begin
			arm_r <= 6'h00;
		end
	end

	// receive flags: hardware set wins over the software clear
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_full_r <= 1'b0;
			idle_r <= 1'b0;
			ovr_r <= 1'b0;
			noise_r <= 1'b0;
			frame_r <= 1'b0;
			par_r <= 1'b0;
		end else begin
			// clears only from the second step, and only when allowed
			if (rd_data) begin
				if (arm_r[5]) rx_full_r <= 1'b0;
				if (arm_r[4]) idle_r <= 1'b0;
				if (arm_r[3]) ovr_r <= 1'b0;
				if (arm_r[2]) noise_r <= 1'b0;
				if (arm_r[1]) frame_r <= 1'b0;
				if (arm_r[0]) par_r <= 1'b0;
			end
			if (take) begin
				rx_full_r <= 1'b1;
				if (nacc_r | bit_noise) noise_r <= 1'b1;
				if (!bit_val) frame_r <= 1'b1;
				if (par_bad) par_r <= 1'b1;
			end
			if (lost) begin
				ovr_r <= 1'b1;
			end
			if (idle_set) begin
				idle_r <= 1'b1;
			end
		end
	end

	// transmitter flags forced set while the module is off
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_empty_r <= 1'b1;
			tx_done_r <= 1'b1;
		end else if (!mod_en) begin
			tx_empty_r <= 1'b1;
			tx_done_r <= 1'b1;
		end
	end

	// read port: data only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			unique case (addr)
				`OFS_CTRL_ONE: rdata <= ctrl1_r;
				`OFS_CTRL_TWO: rdata <= ctrl2_r;
				`OFS_CTRL_THREE: rdata <= {r8_r, ctrl3_r[6:0]};
				`OFS_STATUS_ONE: rdata <= {tx_empty_r, tx_done_r, rx_full_r, idle_r,
					ovr_r, noise_r, frame_r, par_r};
				`OFS_DATA_BUF: rdata <= buf_r;
				`OFS_BREAK_CTRL: rdata <= bctl_r;
				default: rdata <= 8'h00; // unmapped reads as zero
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// interrupt requests; standby silences the receiver side entirely
	always_comb begin
		rx_irq = ~standby & ((rx_full_r & ctrl2_r[`B_RX_FULL_IE]) |
			(idle_r & ctrl2_r[`B_IDLE_IE]));
		err_irq = ~standby & ((ovr_r & ctrl3_r[`B_OVR_IE]) |
			(noise_r & ctrl3_r[`B_NOISE_IE]) | (frame_r & ctrl3_r[`B_FRAME_IE]) |
			(par_r & ctrl3_r[`B_PAR_IE]));
		wait_wake = run & (rx_irq | err_irq);
		tx_irq_allow = mod_en;
		baud_en = mod_en & run;
		rx_enable = rx_on;
		tx_enable = mod_en & ctrl2_r[`B_TX_EN];
	end

	// checks on this block's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_r);

	property p_standby_mute;
		standby |-> !rx_irq && !err_irq;
	endproperty
	a_standby_mute: assert property (p_standby_mute) else $error("irq in standby");

	property p_addr_wake;
		adr_wake && !rx_full_r |=> !standby && rx_full_r && buf_r == $past(sh_r[7:0]);
	endproperty
	a_addr_wake: assert property (p_addr_wake) else $error("address wake wrong");

	property p_idle_wake;
		idle_wake && !(wr_stb && addr == `OFS_CTRL_TWO) |=> !standby && !$rose(idle_r);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

	property p_overrun;
		lost && !rd_data |=> ovr_r && rx_full_r && $stable(buf_r);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost data");

	property p_frame_with_full;
		$rose(frame_r) |-> $rose(rx_full_r);
	endproperty
	a_frame_with_full: assert property (p_frame_with_full) else $error("framing not aligned");

	property p_break_hold;
		dbg_break && !brk_clr |=> !$fell(rx_full_r) && !$fell(ovr_r) && !$fell(idle_r);
	endproperty
	a_break_hold: assert property (p_break_hold) else $error("status cleared in break");

	property p_stop_freeze;
		stop_mode |=> $stable(st_r) && $stable(buf_r) && !$rose(rx_full_r) && !wait_wake;
	endproperty
	a_stop_freeze: assert property (p_stop_freeze) else $error("activity in stop");

	property p_tx_pin;
		mod_en |=> !tx_pin_oe_n && rx_pin_oe_n && tx_pin_out == $past(tx_inv ^ tx_serial);
	endproperty
	a_tx_pin: assert property (p_tx_pin) else $error("pin control wrong");

	property p_disable_flags;
		!mod_en |-> !tx_irq_allow ##1 tx_empty_r && tx_done_r;
	endproperty
	a_disable_flags: assert property (p_disable_flags) else $error("tx flags not set");

	c_addr_wake: cover property (adr_wake);
	c_overrun: cover property (lost);
	c_idle: cover property (idle_set);

endmodule : serial_rx_wakeup_ctrl

/* testbench/async_serial_rx_wakeup_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module async_serial_rx_wakeup_ctrl_tb;
	logic sys_clk, resetn, wr_stb, rd_stb, rx_pin_in, tx_serial, dbg_break, stop_mode;
	logic [2:0] addr; // register index
	logic [7:0] wdata, rdata, d; // bus data and random character
	logic [1:0] port_dout, port_dir; // port settings under the pins
	logic rx_pin_out, rx_pin_oe_n, tx_pin_out, tx_pin_oe_n, rx_line;
	logic bit_stb, bit_val, bit_noise, rx_irq, err_irq, tx_irq_allow, baud_en;
	logic rx_enable, tx_enable, wait_wake;
	int error_cnt, cmp_count;
	serial_rx_wakeup_ctrl u_dut (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.rx_pin_in, .rx_pin_out, .rx_pin_oe_n, .tx_pin_out, .tx_pin_oe_n, .port_dout, .port_dir,
		.tx_serial, .rx_line, .bit_stb, .bit_val, .bit_noise, .dbg_break, .stop_mode, .rx_irq,
		.err_irq, .tx_irq_allow, .baud_en, .rx_enable, .tx_enable, .wait_wake);
	serial_far_tx u_far (.clk(sys_clk), .bit_stb, .bit_val, .bit_noise);
	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// status word: transmitter flags stay set since nothing here clears them
	function automatic logic [7:0] stat(input logic [5:0] f);
		return {2'b11, f};
	endfunction : stat
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wt
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask : wr
	// read data are looked at only in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask : rdc
	task automatic summarize();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	// cut a hang short well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		$display("BAD t=%0t watchdog", $time);
		summarize();
	end
	initial begin
		void'($urandom(64971));
		{resetn, wr_stb, rd_stb, addr, wdata, dbg_break, stop_mode} = '0;
		{rx_pin_in, tx_serial, port_dout, port_dir} = 6'b11_01_10;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		wt(3);
		rdc(0, 8'h00);
		rdc(3, stat(6'h00));
		`CHK(tx_pin_oe_n, 1'b1)
		wr(0, 8'h40);
		wr(1, 8'h2C);
		wr(2, 8'h0F);
		wt(2);
		`CHK({tx_pin_oe_n, rx_pin_oe_n, baud_en, tx_irq_allow}, 4'b0111)
		`CHK({tx_enable, rx_enable}, 2'b11)
		// first character, then a second one while unread
		d = 8'($urandom);
		u_far.send({1'b0, d}, 1'b0, 1'b1, 1'b0);
		wt(2);
		`CHK({rx_irq, wait_wake, err_irq}, 3'b110)
		rdc(3, stat(6'h20));
		u_far.send({1'b0, ~d}, 1'b0, 1'b1, 1'b0);
		wt(2);
		`CHK(err_irq, 1'b1)
		rdc(3, stat(6'h28));
		rdc(4, d);
		rdc(3, stat(6'h00));
		// noisy character with a zero stop bit
		u_far.send({1'b0, d}, 1'b0, 1'b0, 1'b1);
		rdc(3, stat(6'h26));
		wr(2, 8'h08);
		wt(1);
		`CHK(err_irq, 1'b0)
		wr(2, 8'h0F);
		rdc(4, d);
		// even parity, one set bit: mismatch
		wr(0, 8'h42);
		u_far.send(9'h001, 1'b0, 1'b1, 1'b0);
		rdc(3, stat(6'h21));
		rdc(4, 8'h01);
		// nine-bit character lands its top bit in ctrl three
		wr(0, 8'h50);
		u_far.send(9'h1A5, 1'b1, 1'b1, 1'b0);
		rdc(2, 8'h8F);
		rdc(3, stat(6'h20));
		rdc(4, 8'hA5);
		// address-mark wakeup: unmarked character is dropped silently
		wr(0, 8'h48);
		wr(1, 8'h2E);
		u_far.send(9'h012, 1'b0, 1'b1, 1'b0);
		wt(2);
		`CHK(rx_irq, 1'b0)
		rdc(3, stat(6'h00));
		u_far.send(9'h093, 1'b0, 1'b1, 1'b0);
		rdc(1, 8'h2C);
		rdc(3, stat(6'h20));
		rdc(4, 8'h93);
		// idle count start: after start bit counts the ones of 0xFF, after stop does not
		for (int i = 0; i < 2; i++) begin
			wr(0, i ? 8'h44 : 8'h40);
			wr(1, 8'h3C);
			u_far.send(9'h0FF, 1'b0, 1'b1, 1'b0);
			u_far.ones(8);
			rdc(3, stat(i ? 6'h20 : 6'h30));
			rdc(4, 8'hFF);
		end
		// idle-line wakeup sets no flag
		wr(0, 8'h40);
		wr(1, 8'h2E);
		u_far.ones(10);
		rdc(1, 8'h2C);
		rdc(3, stat(6'h00));
		// debug break: clears stick only with break clear enable
		u_far.send({1'b0, d}, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			wr(5, i ? 8'h80 : 8'h00);
			@(posedge sys_clk);
			dbg_break <= 1'b1;
			rdc(3, stat(6'h20));
			rdc(4, d);
			@(posedge sys_clk);
			dbg_break <= 1'b0;
			rdc(3, stat(i ? 6'h00 : 6'h20));
		end
		// stop mode: frozen, character ignored, registers kept
		@(posedge sys_clk);
		stop_mode <= 1'b1;
		u_far.send({1'b0, d}, 1'b0, 1'b1, 1'b0);
		wt(1);
		`CHK({baud_en, rx_enable, wait_wake}, 3'b000)
		@(posedge sys_clk);
		stop_mode <= 1'b0;
		rdc(3, stat(6'h00));
		rdc(0, 8'h40);
		@(posedge sys_clk);
		rx_pin_in <= 1'b0;
		wt(4);
		`CHK(rx_line, 1'b0)
		// loopback, plain then inverted
		for (int i = 0; i < 2; i++) begin
			wr(0, i ? 8'hE0 : 8'hC0);
			@(posedge sys_clk);
			tx_serial <= 1'($urandom);
			wt(2);
			`CHK(rx_line, tx_serial ^ i[0])
			`CHK(tx_pin_out, tx_serial ^ i[0])
		end
		wr(0, 8'h00);
		wt(2);
		`CHK({tx_irq_allow, baud_en, tx_pin_oe_n}, 3'b001)
		`CHK({rx_pin_out, rx_pin_oe_n, tx_enable}, 3'b000)
		rdc(3, stat(6'h00));
		rdc(7, 8'h00);
		summarize();
	end
endmodule : async_serial_rx_wakeup_ctrl_tb

/* testbench/serial_far_tx.sv */
`timescale 1ns/1ps
// far-end transmitter as the bit sampler reports it: one decided bit per strobe
module serial_far_tx (
	input wire logic clk, // bench clock
	output logic bit_stb, // one bit decided
	output logic bit_val, // decided level
	output logic bit_noise // bit was noisy
);
	initial begin
		bit_stb = 1'b0;
		bit_val = 1'b1;
		bit_noise = 1'b0;
	end
	// strobe for one cycle, then a gap; data flips while invalid so stale levels never pass
	task automatic put(input logic v, input logic nz);
		@(posedge clk);
		bit_stb <= 1'b1;
		bit_val <= v;
		bit_noise <= nz;
		@(posedge clk);
		bit_stb <= 1'b0;
		bit_val <= ~v;
		bit_noise <= ~nz;
	endtask : put
	// start bit, data lsb first, then the stop level asked for
	task automatic send(input logic [8:0] d, input logic nine, input logic stp, input logic nz);
		put(1'b0, 1'b0);
		for (int i = 0; i < (nine ? 9 : 8); i++) begin
			put(d[i], nz && i == 3);
		end
		put(stp, 1'b0);
	endtask : send
	// a run of idle ones
	task automatic ones(input int n);
		repeat (n) put(1'b1, 1'b0);
	endtask : ones
endmodule : serial_far_tx
